// ===== watchdog_pkg.sv
// watchdog_pkg: constants shared by the watchdog and its tick divider.
// assumes a 10 MHz system clock and the 12-bit CPU register address space.
package watchdog_pkg;
  localparam int CLK_HZ = 10_000_000;
  localparam int RC_HZ = 10_000;
  // whole system clocks per nominal rc oscillator period
  localparam int TICK_CYCLES = CLK_HZ / RC_HZ;
  localparam int ADDR_W = 12;
  localparam logic [11:0] ADDR_RESET_CAUSE = 12'hFF0;
  localparam logic [11:0] ADDR_RELOAD_UPPER = 12'hFF1;
  localparam logic [11:0] ADDR_RELOAD_HIGH = 12'hFF2;
  localparam logic [11:0] ADDR_RELOAD_LOW = 12'hFF3;
  localparam logic [7:0] RELOAD_UPPER_RESET = 8'h00;
  localparam logic [7:0] RELOAD_HIGH_RESET = 8'h04;
  localparam logic [7:0] RELOAD_LOW_RESET = 8'h00;
  localparam logic [7:0] RESET_CAUSE_RESET = 8'h00;
  localparam logic [7:0] RESET_CAUSE_READ_KEEP = 8'h0F;
  localparam int RESET_CAUSE_WDT_BIT = 5;
  localparam logic [23:0] REFRESH_FLOOR = 24'h000002;
  localparam logic [23:0] MIN_RELOAD = 24'h000004;
  localparam logic [23:0] COUNT_ONE = 24'h000001;
  localparam logic [23:0] COUNT_ZERO = 24'h000000;
  localparam logic [7:0] READ_UNMAPPED = 8'h00;
  typedef enum logic {WD_OFF, WD_ON} wd_state_type;
endpackage : watchdog_pkg

// ===== rc_tick_divider.sv
// rc_tick_divider: one-cycle enable standing in for the watchdog rc oscillator.
// assumes a single system clock; tick is registered.
`timescale 1ns/1ns
module rc_tick_divider #(
  parameter int DIVIDE = watchdog_pkg::TICK_CYCLES
) (
  input wire logic clk,
  input wire logic rst_n,
  output logic tick
);
  import watchdog_pkg::*;
  localparam int CW = $clog2(DIVIDE);
  localparam logic [CW-1:0] LAST = CW'(DIVIDE - 1);

  typedef struct packed {
    logic [CW-1:0] count;
    logic tick;
  } div_regs_type;

  div_regs_type r;
  div_regs_type next_r;

  always_comb begin
    next_r = r;
    next_r.tick = 1'b0;
    if (r.count == LAST) begin
      next_r.count = '0;
      next_r.tick = 1'b1;
    end else begin
      next_r.count = r.count + CW'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign tick = r.tick;
endmodule : rc_tick_divider

// ===== watchdog_unit.sv
// watchdog_unit: 24-bit reloadable down-counting watchdog with byte reload registers.
// assumes cpu register strobes and option bits are synchronous to clk.
// What this block does
// - single time-out response at terminal count
// - counts only on rc oscillator ticks
// - two states; once on, never off
// - enabled by instruction or always-on option
// - always-on option starts counting after reset
// - reload value is upper, high, low bytes
// - refresh ignored at count two or lower
// - reads give live count, writes set reload
// - response select: set resets, clear interrupts
// - always-on gives no way to disable
// - reset cause records time-out, read clears upper
`timescale 1ns/1ns
module watchdog_unit #(
  parameter int TICK_DIVIDE = watchdog_pkg::TICK_CYCLES
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic wdt_instr,
  input wire logic always_on_option,
  input wire logic timeout_response_select,
  input wire logic [watchdog_pkg::ADDR_W-1:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic watchdog_reset,
  output logic watchdog_irq
);
  import watchdog_pkg::*;

  typedef struct packed {
    wd_state_type mode;
    logic started;
    logic [23:0] count;
    logic [7:0] reload_upper_byte;
    logic [7:0] reload_high_byte;
    logic [7:0] reload_low_byte;
    logic [7:0] rdata;
    logic [7:0] reset_cause_register;
    logic reset_req;
    logic irq_req;
  } wd_regs_type;

  localparam wd_regs_type RESET_STATE = '{
    mode: WD_OFF,
    started: 1'b0,
    count: COUNT_ZERO,
    reload_upper_byte: RELOAD_UPPER_RESET,
    reload_high_byte: RELOAD_HIGH_RESET,
    reload_low_byte: RELOAD_LOW_RESET,
    rdata: READ_UNMAPPED,
    reset_cause_register: RESET_CAUSE_RESET,
    reset_req: 1'b0,
    irq_req: 1'b0
  };

  wd_regs_type r;
  wd_regs_type next_r;
  logic tick;
  logic [23:0] reload;
  logic terminal_step;

  // slow rate is an enable on clk, so there is no clock crossing to guard
  rc_tick_divider #(.DIVIDE(TICK_DIVIDE)) u_tick (
    .clk(clk),
    .rst_n(rst_n),
    .tick(tick)
  );

  assign reload = {r.reload_upper_byte, r.reload_high_byte, r.reload_low_byte};
  // last tick of a load; the response and the cause bit are raised on it
  assign terminal_step = r.mode == WD_ON && tick && r.count == COUNT_ONE;

  always_comb begin
    next_r = r;
    next_r.reset_req = 1'b0;
    next_r.irq_req = 1'b0;
    if (reg_wr) begin
      case (reg_addr)
        ADDR_RELOAD_UPPER: next_r.reload_upper_byte = reg_wdata;
        ADDR_RELOAD_HIGH: next_r.reload_high_byte = reg_wdata;
        ADDR_RELOAD_LOW: next_r.reload_low_byte = reg_wdata;
        default: next_r.rdata = r.rdata;
      endcase
    end
    // writes to the reset cause address hit the default arm and change nothing
    if (reg_rd) begin
      case (reg_addr)
        ADDR_RELOAD_UPPER: next_r.rdata = r.count[23:16];
        ADDR_RELOAD_HIGH: next_r.rdata = r.count[15:8];
        ADDR_RELOAD_LOW: next_r.rdata = r.count[7:0];
        ADDR_RESET_CAUSE: begin
          next_r.rdata = r.reset_cause_register;
          next_r.reset_cause_register = r.reset_cause_register & RESET_CAUSE_READ_KEEP;
        end
        default: next_r.rdata = READ_UNMAPPED;
      endcase
    end
    // option captured once after reset release; an active-low bit means auto start
    if (!r.started) begin
      next_r.started = 1'b1;
      if (!always_on_option) begin
        next_r.mode = WD_ON;
        next_r.count = reload;
      end
    end
    case (r.mode)
      WD_OFF: begin
        if (r.started && wdt_instr) begin
          next_r.mode = WD_ON;
          next_r.count = reload;
        end
      end
      WD_ON: begin
        // no path back to off: only a device reset stops it
        // refresh outranks a tick landing in the same cycle
        if (wdt_instr && r.count > REFRESH_FLOOR) begin
          next_r.count = reload;
        end else if (tick && r.count != COUNT_ZERO) begin
          next_r.count = r.count - COUNT_ONE;
          if (r.count == COUNT_ONE) begin
            // parks at zero, so the response fires once per load
            if (timeout_response_select) begin
              next_r.reset_req = 1'b1;
            end else begin
              next_r.irq_req = 1'b1;
            end
            next_r.reset_cause_register[RESET_CAUSE_WDT_BIT] = 1'b1;
          end
        end
      end
      default: next_r.mode = WD_OFF;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      r <= RESET_STATE;
    end else begin
      r <= next_r;
    end
  end

  assign reg_rdata = r.rdata;
  assign watchdog_reset = r.reset_req;
  assign watchdog_irq = r.irq_req;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  AST_ONE_SHOT: assert property ((watchdog_reset || watchdog_irq) |=> !(watchdog_reset || watchdog_irq) [*8])
    else $error("time-out response repeated");
  AST_FIRE_AT_TERMINAL: assert property ((r.mode == WD_ON && tick && r.count == COUNT_ONE)
    |=> (watchdog_reset || watchdog_irq) && r.count == COUNT_ZERO)
    else $error("no response at terminal count");
  AST_COUNT_ONLY_ON_TICK: assert property ((r.mode == WD_ON && !tick && !wdt_instr) |=> $stable(r.count))
    else $error("count moved without a tick");
  AST_STAYS_ON: assert property (r.mode == WD_ON |=> r.mode == WD_ON)
    else $error("watchdog turned off");
  AST_INSTR_ENABLES: assert property ((r.mode == WD_OFF && r.started && wdt_instr)
    |=> r.mode == WD_ON && r.count == $past(reload))
    else $error("instruction did not enable with reload");
  AST_ALWAYS_ON: assert property ((!r.started && !always_on_option) |=> r.mode == WD_ON)
    else $error("always-on option did not start counter");
  AST_REFRESH_IGNORED: assert property ((r.mode == WD_ON && wdt_instr && r.count <= REFRESH_FLOOR)
    |=> r.count <= $past(r.count))
    else $error("late refresh accepted");
  AST_READ_LIVE_COUNT: assert property ((reg_rd && reg_addr == ADDR_RELOAD_LOW)
    |=> reg_rdata == $past(r.count[7:0]))
    else $error("read did not return live count");
  AST_WRITE_RELOAD: assert property ((reg_wr && reg_addr == ADDR_RELOAD_UPPER)
    |=> r.reload_upper_byte == $past(reg_wdata))
    else $error("upper reload byte not written");
  AST_RESPONSE_SELECT: assert property (watchdog_reset |-> $past(timeout_response_select))
    else $error("reset issued while interrupt selected");
  AST_CAUSE_RECORDED: assert property ((watchdog_reset || watchdog_irq)
    |-> r.reset_cause_register[RESET_CAUSE_WDT_BIT])
    else $error("time-out not recorded");
  // every byte lane on its own, so a swapped lane cannot hide behind another
  AST_WRITE_HIGH: assert property ((reg_wr && reg_addr == ADDR_RELOAD_HIGH)
    |=> r.reload_high_byte == $past(reg_wdata))
    else $error("high reload byte not written");
  AST_WRITE_LOW: assert property ((reg_wr && reg_addr == ADDR_RELOAD_LOW)
    |=> r.reload_low_byte == $past(reg_wdata))
    else $error("low reload byte not written");
  AST_READ_UPPER_COUNT: assert property ((reg_rd && reg_addr == ADDR_RELOAD_UPPER)
    |=> reg_rdata == $past(r.count[23:16]))
    else $error("upper read did not return live count");
  AST_READ_HIGH_COUNT: assert property ((reg_rd && reg_addr == ADDR_RELOAD_HIGH)
    |=> reg_rdata == $past(r.count[15:8]))
    else $error("high read did not return live count");
  AST_IRQ_SELECT: assert property (watchdog_irq
    |-> !$past(timeout_response_select))
    else $error("interrupt issued while reset selected");
  AST_CAUSE_READ_CLEAR: assert property ((reg_rd && reg_addr == ADDR_RESET_CAUSE && !terminal_step)
    |=> (r.reset_cause_register & ~RESET_CAUSE_READ_KEEP) == 8'h00)
    else $error("reset cause upper bits not cleared by read");
  AST_DECREMENT_ON_TICK: assert property ((r.mode == WD_ON && tick && !wdt_instr && r.count != COUNT_ZERO)
    |=> r.count == $past(r.count) - COUNT_ONE)
    else $error("count did not step down on a tick");
  AST_REFRESH_RELOADS: assert property ((r.mode == WD_ON && wdt_instr && r.count > REFRESH_FLOOR)
    |=> r.count == $past(reload))
    else $error("refresh did not reload the counter");
  AST_PARKS_AT_ZERO: assert property ((r.mode == WD_ON && r.count == COUNT_ZERO)
    |=> r.count == COUNT_ZERO)
    else $error("counter left zero without a reset");
  AST_OFF_NEEDS_ENABLE: assert property ((r.mode == WD_OFF && r.started && !wdt_instr)
    |=> r.mode == WD_OFF)
    else $error("watchdog started without an enable");
  AST_QUIET_WHEN_OFF: assert property (r.mode == WD_OFF
    |=> !(watchdog_reset || watchdog_irq))
    else $error("time-out response while off");

  COV_RESET_TIMEOUT: cover property (watchdog_reset);
  COV_IRQ_TIMEOUT: cover property (watchdog_irq);
  COV_REFRESH: cover property (r.mode == WD_ON && wdt_instr && r.count > REFRESH_FLOOR);
  COV_LATE_REFRESH: cover property (r.mode == WD_ON && wdt_instr && r.count <= REFRESH_FLOOR);
  COV_AUTO_START: cover property (!r.started && !always_on_option);
endmodule : watchdog_unit

// ===== testbench.sv
// testbench: self-checking bench for watchdog_unit with a shortened rc tick.
// assumes watchdog_pkg is compiled first; inputs driven on the falling edge.
`timescale 1ns/1ns
module testbench;
  import watchdog_pkg::*;
  localparam int DIV = 4;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic wdt_instr = 1'b0;
  logic always_on_option = 1'b1;
  logic timeout_response_select = 1'b1;
  logic [ADDR_W-1:0] reg_addr = 12'h000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] reg_rdata;
  logic watchdog_reset;
  logic watchdog_irq;
  int n_mismatch = 0;
  int samples_checked = 0;
  int n_pulse = 0;
  // reference copy of the 24-bit reload value, kept from the register rules
  int model_reload = 0;
  always #50 clk = ~clk;
  watchdog_unit #(.TICK_DIVIDE(DIV)) DUT (.clk(clk), .rst_n(rst_n), .wdt_instr(wdt_instr),
    .always_on_option(always_on_option), .timeout_response_select(timeout_response_select),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .watchdog_reset(watchdog_reset), .watchdog_irq(watchdog_irq));
  // counts every response pulse, to catch a second one
  always @(posedge clk) if (rst_n && (watchdog_reset === 1'b1 || watchdog_irq === 1'b1)) n_pulse <= n_pulse + 1;
  task stop_test;
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : stop_test
  task check(input logic ok, input string msg);
    samples_checked++;
    if (ok !== 1'b1) begin
      n_mismatch++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask : check
  task do_reset(input logic ao);
    @(negedge clk);
    rst_n = 1'b0;
    always_on_option = ao;
    model_reload = {8'h00, RELOAD_UPPER_RESET, RELOAD_HIGH_RESET, RELOAD_LOW_RESET};
    repeat (4) @(negedge clk);
    rst_n = 1'b1;
  endtask : do_reset
  task wr(input logic [11:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    case (a)
      ADDR_RELOAD_UPPER: model_reload[23:16] = d;
      ADDR_RELOAD_HIGH: model_reload[15:8] = d;
      ADDR_RELOAD_LOW: model_reload[7:0] = d;
      default: model_reload = model_reload;
    endcase
    @(negedge clk);
    reg_wr = 1'b0;
  endtask : wr
  task rd(input logic [11:0] a, output logic [7:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk);
    reg_rd = 1'b0;
    d = reg_rdata;
  endtask : rd
  task instr;
    @(negedge clk);
    wdt_instr = 1'b1;
    @(negedge clk);
    wdt_instr = 1'b0;
  endtask : instr
  // tick phase is unknown, so the window allows one tick of slack
  task wait_pulse(input int lo, input int hi, input logic as_reset);
    int n;
    n = 0;
    while (watchdog_reset !== 1'b1 && watchdog_irq !== 1'b1 && n < hi) begin
      @(negedge clk);
      n++;
    end
    check(n >= lo && n < hi, "time-out moment");
    check(watchdog_reset === as_reset && watchdog_irq === !as_reset, "response kind");
  endtask : wait_pulse
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    stop_test();
  end
  initial begin
    logic [7:0] b;
    int r;
    logic sel;
    r = $urandom(88461);
    do_reset(1'b1);
    @(negedge clk);
    for (int a = 12'hFF0; a <= 12'hFF4; a++) begin
      rd(a[11:0], b);
      check(b === 8'h00, "idle read");
    end
    r = 8 + $urandom % 32;
    sel = 1'($urandom % 2);
    timeout_response_select = sel;
    wr(ADDR_RELOAD_UPPER, 8'h00);
    wr(ADDR_RELOAD_HIGH, 8'h00);
    wr(ADDR_RELOAD_LOW, r[7:0]);
    wr(12'h123, 8'hFF);
    instr();
    rd(ADDR_RELOAD_LOW, b);
    check(b <= r && b >= r - 2, "live count");
    wait_pulse((model_reload - 1) * DIV - 2, model_reload * DIV + 3, sel);
    rd(ADDR_RESET_CAUSE, b);
    check(b[RESET_CAUSE_WDT_BIT] === 1'b1, "cause set");
    rd(ADDR_RESET_CAUSE, b);
    check(b[7:4] === 4'h0, "cause cleared");
    instr();
    repeat ((r + 2) * DIV) @(negedge clk);
    check(n_pulse === 1, "single response");
    // refresh in mid-count restarts the full reload
    do_reset(1'b1);
    timeout_response_select = !sel;
    // high byte comes back as 04h after reset
    wr(ADDR_RELOAD_HIGH, 8'h00);
    wr(ADDR_RELOAD_LOW, r[7:0]);
    instr();
    repeat (r * DIV / 2) @(negedge clk);
    instr();
    wait_pulse((model_reload - 1) * DIV, model_reload * DIV + 3, !sel);
    // refresh at count two must not save it
    do_reset(1'b1);
    timeout_response_select = sel;
    wr(ADDR_RELOAD_HIGH, 8'h00);
    wr(ADDR_RELOAD_LOW, r[7:0]);
    instr();
    repeat ((r - 1) * DIV - DIV / 2 - 1) @(negedge clk);
    instr();
    wait_pulse(0, 2 * DIV + 3, sel);
    // option low: runs from reset with the reset reload of 000400h
    do_reset(1'b0);
    wait_pulse((model_reload - 1) * DIV, model_reload * DIV + 4, sel);
    stop_test();
  end
endmodule : testbench
